// ### src/tac_top.sv
// Trigger detection, acquisition sequencing and setup persistence
module tac_top #(
    parameter int REC_AW    = tac_pkg::REC_AW,
    parameter int AVG_LOG2  = tac_pkg::AVG_LOG2,
    parameter int SAVE_CYC  = tac_pkg::SAVE_IDLE_CYC,
    parameter int LONG_CYC  = tac_pkg::LONG_CYC,
    parameter int GATE_CYC  = tac_pkg::GATE_CYC,
    parameter int AUTO_CYC  = tac_pkg::AUTO_CYC
) (
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic [7:0]         ch1_in,
    input  wire logic [7:0]         ch2_in,
    input  wire logic [7:0]         ext_in,
    input  wire logic               line_in,
    input  wire logic               run_btn_in,
    input  wire logic               single_btn_in,
    input  wire logic               force_btn_in,
    input  wire logic               autoset_btn_in,
    input  wire logic               trig_btn_in,
    input  wire logic               cfg_we_in,
    input  wire tac_pkg::tac_cfg_s  cfg_in,
    input  wire logic               save_in,
    input  wire logic               recall_in,
    input  wire logic [3:0]         slot_in,
    output tac_pkg::tac_cfg_s       setup_out,
    output logic                    nv_commit_out,
    output logic                    running_out,
    output logic                    armed_out,
    output logic                    triggered_out,
    output logic                    disp_valid_out,
    output tac_pkg::tac_point_s     disp_data_out,
    output logic                    disp_last_out,
    output logic [31:0]             trig_freq_out,
    output logic                    trig_view_out,
    output logic                    autoset_out,
    output logic                    autorange_out
);
    localparam int REC_LEN = 2 ** REC_AW;
    localparam logic [7:0] AVG_TOP = 8'((1 << AVG_LOG2) - 1);

    // Pin synchronisers; a change counts once stages two and three agree
    logic [tac_pkg::PINS-1:0] pin_raw, s1, s2, s3, pin_q, pin_d, next_pin_q, rise;
    assign pin_raw = {trig_btn_in, autoset_btn_in, force_btn_in, single_btn_in, run_btn_in, line_in};
    assign next_pin_q = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & pin_q);
    assign rise = pin_q & ~pin_d;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            pin_q <= '0;
            pin_d <= '0;
        end
        else
        begin
            s1    <= pin_raw;
            s2    <= s1;
            s3    <= s2;
            pin_q <= next_pin_q;
            pin_d <= pin_q;
        end
    end

    // Long press timers: index 0 autoset, 1 trigger menu
    logic [31:0] press_cnt [2];
    logic [1:0]  long_edge, short_rel, long_on;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_press
            localparam int B = tac_pkg::PIN_AUTOSET + gi;
            logic [31:0] next_cnt;
            always_comb
            begin
                next_cnt = '0;
                if (pin_q[B])
                    next_cnt = long_on[gi] ? press_cnt[gi] : press_cnt[gi] + 32'h1;
            end
            assign long_on[gi]   = press_cnt[gi] == 32'(LONG_CYC);
            assign long_edge[gi] = pin_q[B] && press_cnt[gi] == 32'(LONG_CYC - 1);
            assign short_rel[gi] = !pin_q[B] && pin_d[B] && !long_on[gi];
            always_ff @(posedge clk_in)
            begin
                if (rst_in)
                    press_cnt[gi] <= '0;
                else
                    press_cnt[gi] <= next_cnt;
            end
        end
    endgenerate

    logic next_autorange;
    assign next_autorange = long_edge[0] ? ~autorange_out : autorange_out;
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            autorange_out <= 1'b0;
            autoset_out   <= 1'b0;
            trig_view_out <= 1'b0;
        end
        else
        begin
            autorange_out <= next_autorange;
            autoset_out   <= short_rel[0];
            trig_view_out <= long_on[1] && pin_q[tac_pkg::PIN_TRIG];
        end
    end

    // Setup store; slots are not reset so they outlive a reset
    tac_pkg::tac_cfg_s slots [tac_pkg::LAST_SLOT+1];
    tac_pkg::tac_cfg_s setup, next_setup;
    logic        restore;
    logic [31:0] idle_cnt, next_idle;
    logic        commit, slot_ok;
    assign slot_ok = slot_in < 4'(tac_pkg::SLOTS);
    assign commit  = idle_cnt == 32'(SAVE_CYC - 1);
    assign setup_out = setup;
    always_comb
    begin
        next_setup = setup;
        next_idle  = (idle_cnt == 32'(SAVE_CYC)) ? idle_cnt : idle_cnt + 32'h1;
        if (restore)
            next_setup = slots[tac_pkg::LAST_SLOT];
        else if (recall_in && slot_ok)
        begin
            next_setup = slots[slot_in];
            next_idle  = '0;
        end
        else if (cfg_we_in)
        begin
            next_setup = cfg_in;
            next_idle  = '0;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            setup         <= tac_pkg::CFG_RST;
            restore       <= 1'b1;
            idle_cnt      <= 32'(SAVE_CYC);
            nv_commit_out <= 1'b0;
        end
        else
        begin
            setup         <= next_setup;
            restore       <= 1'b0;
            idle_cnt      <= next_idle;
            nv_commit_out <= commit;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (commit)
            slots[tac_pkg::LAST_SLOT] <= setup;
        if (save_in && slot_ok)
            slots[slot_in] <= setup;
    end

    // Trigger path: source, coupling, level and type
    tac_pkg::tac_src_e src;
    logic [7:0]  raw, cond;
    logic [11:0] dc_est, next_dc;
    logic        above, above_d;
    logic [15:0] run_len, next_run;
    logic        trig_evt;
    always_comb
    begin
        src = setup.src;
        if (src == tac_pkg::SRC_LINE && setup.trig_type != tac_pkg::TAC_EDGE)
            src = tac_pkg::SRC_CH1;
        case (src)
            tac_pkg::SRC_CH1: raw = ch1_in;
            tac_pkg::SRC_CH2: raw = ch2_in;
            tac_pkg::SRC_EXT: raw = ext_in;
            default: raw = pin_q[tac_pkg::PIN_LINE] ? tac_pkg::LVL_FULL : tac_pkg::LVL_ZERO;
        endcase
        // Ac coupling removes a slow running mean from the detector input and from the ch1 points in trigger view
        next_dc = dc_est + 12'(raw) - 12'(dc_est[11:tac_pkg::AC_SHIFT]);
        cond = setup.coupling_ac ? raw - dc_est[11:tac_pkg::AC_SHIFT] + tac_pkg::LVL_MID : raw;
        above = cond >= setup.level;
        next_run = (above != above_d) ? '0 : ((&run_len) ? run_len : run_len + 16'h1);
        case (setup.trig_type)
            tac_pkg::TAC_EDGE:  trig_evt = setup.slope_fall ? (above_d && !above) : (!above_d && above);
            tac_pkg::TAC_PULSE: trig_evt = above_d && !above && run_len >= setup.pw_min;
            tac_pkg::TAC_VIDEO: trig_evt = !above_d && above && run_len >= setup.pw_min;
            default: trig_evt = 1'b0;
        endcase
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            dc_est  <= {tac_pkg::LVL_MID, 4'h0};
            above_d <= 1'b0;
            run_len <= '0;
        end
        else
        begin
            dc_est  <= next_dc;
            above_d <= above;
            run_len <= next_run;
        end
    end

    // Trigger frequency: edge and pulse events counted per gate window
    logic [31:0] gate_cnt, evt_cnt, next_gate, next_evt, next_freq;
    logic        gate_end, count_evt;
    assign gate_end  = gate_cnt == 32'(GATE_CYC - 1);
    assign count_evt = trig_evt && setup.trig_type != tac_pkg::TAC_VIDEO;
    always_comb
    begin
        next_gate = gate_end ? '0 : gate_cnt + 32'h1;
        next_evt  = gate_end ? '0 : evt_cnt + 32'(count_evt);
        next_freq = gate_end ? evt_cnt + 32'(count_evt) : trig_freq_out;
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            gate_cnt      <= '0;
            evt_cnt       <= '0;
            trig_freq_out <= '0;
        end
        else
        begin
            gate_cnt      <= next_gate;
            evt_cnt       <= next_evt;
            trig_freq_out <= next_freq;
        end
    end

    // Sampler: divider sets point spacing, peak tracks extremes between ticks
    logic [15:0] div_cnt, next_div;
    logic        tick;
    logic [7:0]  v1, pk1_hi, pk1_lo, pk2_hi, pk2_lo;
    tac_pkg::tac_point_s pt, next_pt, pk_pt;
    logic        pt_v;
    assign tick = div_cnt >= setup.tb_div;
    assign v1   = trig_view_out ? cond : ch1_in;
    always_comb
    begin
        next_div = tick ? '0 : div_cnt + 16'h1;
        pk_pt.ch1_hi = (v1 > pk1_hi) ? v1 : pk1_hi;
        pk_pt.ch1_lo = (v1 < pk1_lo) ? v1 : pk1_lo;
        pk_pt.ch2_hi = (ch2_in > pk2_hi) ? ch2_in : pk2_hi;
        pk_pt.ch2_lo = (ch2_in < pk2_lo) ? ch2_in : pk2_lo;
        next_pt = pt;
        if (tick)
            next_pt = (setup.acq == tac_pkg::ACQ_PEAK) ? pk_pt
                    : tac_pkg::tac_point_s'{ch2_in, ch2_in, v1, v1};
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in || tick)
        begin
            pk1_hi <= tac_pkg::LVL_ZERO;
            pk1_lo <= tac_pkg::LVL_FULL;
            pk2_hi <= tac_pkg::LVL_ZERO;
            pk2_lo <= tac_pkg::LVL_FULL;
        end
        else
        begin
            pk1_hi <= pk_pt.ch1_hi;
            pk1_lo <= pk_pt.ch1_lo;
            pk2_hi <= pk_pt.ch2_hi;
            pk2_lo <= pk_pt.ch2_lo;
        end
        if (rst_in)
        begin
            div_cnt <= '0;
            pt      <= '0;
            pt_v    <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div;
            pt      <= next_pt;
            pt_v    <= tick;
        end
    end

    // Acquisition sequencer
    tac_pkg::tac_state_e state, next_state;
    tac_pkg::tac_point_s rec [REC_LEN];
    logic [REC_AW-1:0] wptr, next_wptr, start, next_start, ridx, next_ridx;
    logic [REC_AW:0]   cnt, next_cnt, pre;
    logic [31:0]       auto_cnt, next_auto;
    logic              next_running, single, next_single, fire, rec_we, rd_issue, go;
    assign pre = (setup.pretrig > 16'(REC_LEN - 1)) ? (REC_AW+1)'(REC_LEN - 1)
                                                   : (REC_AW+1)'(setup.pretrig);
    assign armed_out = state == tac_pkg::ST_WAIT;
    always_comb
    begin
        next_state = state;
        next_wptr = wptr;
        next_cnt = cnt;
        next_start = start;
        next_ridx = ridx;
        next_auto = '0;
        next_running = running_out;
        next_single = single;
        fire = 1'b0;
        rec_we = 1'b0;
        rd_issue = 1'b0;
        go = 1'b0;
        case (state)
            tac_pkg::ST_IDLE: ;
            tac_pkg::ST_PRE:
            begin
                rec_we = pt_v;
                if (cnt >= pre)
                    next_state = tac_pkg::ST_WAIT;
                fire = rise[tac_pkg::PIN_FORCE];
            end
            tac_pkg::ST_WAIT:
            begin
                rec_we = pt_v;
                next_auto = auto_cnt + 32'h1;
                fire = trig_evt || rise[tac_pkg::PIN_FORCE]
                    || (!setup.mode_normal && auto_cnt >= 32'(AUTO_CYC - 1));
            end
            tac_pkg::ST_POST:
            begin
                if (cnt == (REC_AW+1)'(REC_LEN) - pre)
                begin
                    next_state = tac_pkg::ST_READ;
                    next_ridx = '0;
                end
                else
                    rec_we = pt_v;
            end
            tac_pkg::ST_READ:
            begin
                rd_issue = 1'b1;
                next_ridx = ridx + 1'b1;
                if (ridx == REC_AW'(REC_LEN - 1))
                begin
                    if (single)
                    begin
                        next_state = tac_pkg::ST_IDLE;
                        next_running = 1'b0;
                    end
                    else
                        go = 1'b1;
                end
            end
            default: next_state = tac_pkg::ST_IDLE;
        endcase
        if (rec_we)
        begin
            next_wptr = wptr + 1'b1;
            next_cnt = cnt + 1'b1;
        end
        if (fire)
        begin
            next_state = tac_pkg::ST_POST;
            next_cnt = '0;
            next_start = next_wptr - pre[REC_AW-1:0];
        end
        // A stop wins over the sequence; single restarts it like run
        if (rise[tac_pkg::PIN_SINGLE])
        begin
            next_running = 1'b1;
            next_single = 1'b1;
            go = 1'b1;
        end
        else if (rise[tac_pkg::PIN_RUN])
        begin
            next_running = !running_out;
            next_single = 1'b0;
            go = !running_out;
            if (running_out)
                next_state = tac_pkg::ST_IDLE;
        end
        if (go)
        begin
            next_state = tac_pkg::ST_PRE;
            next_cnt = '0;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state <= tac_pkg::ST_IDLE;
            wptr <= '0;
            cnt <= '0;
            start <= '0;
            ridx <= '0;
            auto_cnt <= '0;
            running_out <= 1'b0;
            single <= 1'b0;
            triggered_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            wptr <= next_wptr;
            cnt <= next_cnt;
            start <= next_start;
            ridx <= next_ridx;
            auto_cnt <= next_auto;
            running_out <= next_running;
            single <= next_single;
            triggered_out <= fire;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (rec_we)
            rec[wptr] <= pt;
    end

    // Readout with point-by-point averaging over 2**AVG_LOG2 records
    logic [4*tac_pkg::ACC_W-1:0] acc [REC_LEN];
    logic [4*tac_pkg::ACC_W-1:0] sum;
    tac_pkg::tac_point_s rd_pt, avg_pt, next_data;
    logic [REC_AW-1:0] rd_idx;
    logic        rd_v, rd_last, acc_we, next_dv, next_dl;
    logic [7:0]  avg_cnt, next_avg;
    always_comb
    begin
        for (int f = 0; f < 4; f++)
        begin
            sum[f*16 +: 16] = ((avg_cnt == 8'h00) ? 16'h0000 : acc[rd_idx][f*16 +: 16])
                            + {8'h00, rd_pt[f*8 +: 8]};
            avg_pt[f*8 +: 8] = 8'(sum[f*16 +: 16] >> AVG_LOG2);
        end
        next_dv = 1'b0;
        next_dl = 1'b0;
        next_data = disp_data_out;
        next_avg = (setup.acq == tac_pkg::ACQ_AVG) ? avg_cnt : 8'h00;
        acc_we = 1'b0;
        if (rd_v && setup.acq == tac_pkg::ACQ_AVG)
        begin
            acc_we = 1'b1;
            next_dv = avg_cnt == AVG_TOP;
            next_dl = rd_last && avg_cnt == AVG_TOP;
            next_data = avg_pt;
            if (rd_last)
                next_avg = (avg_cnt == AVG_TOP) ? 8'h00 : avg_cnt + 8'h01;
        end
        else if (rd_v)
        begin
            next_dv = 1'b1;
            next_dl = rd_last;
            next_data = rd_pt;
        end
    end
    always_ff @(posedge clk_in)
    begin
        rd_pt <= rec[start + ridx];
        rd_idx <= ridx;
        if (acc_we)
            acc[rd_idx] <= sum;
        if (rst_in)
        begin
            rd_v <= 1'b0;
            rd_last <= 1'b0;
            avg_cnt <= '0;
            disp_valid_out <= 1'b0;
            disp_last_out <= 1'b0;
            disp_data_out <= '0;
        end
        else
        begin
            rd_v <= rd_issue;
            rd_last <= rd_issue && ridx == REC_AW'(REC_LEN - 1);
            avg_cnt <= next_avg;
            disp_valid_out <= next_dv;
            disp_last_out <= next_dl;
            disp_data_out <= next_data;
        end
    end
endmodule : tac_top

// ### src/tac_pkg.sv
// Constants and types for trigger and acquisition control
package tac_pkg;
    localparam int SW            = 8;
    localparam int REC_AW        = 10;
    localparam int AVG_LOG2      = 4;
    localparam int ACC_W         = 16;
    localparam int SLOTS         = 10;
    localparam int LAST_SLOT     = 10;
    localparam int AC_SHIFT      = 4;
    localparam int CLK_HZ        = 250_000_000;
    localparam int SAVE_IDLE_MS  = 5000;
    localparam int LONG_PRESS_MS = 1500;
    localparam int GATE_MS       = 1000;
    localparam int AUTO_MS       = 100;
    localparam int SAVE_IDLE_CYC = CLK_HZ / 1000 * SAVE_IDLE_MS;
    localparam int LONG_CYC      = CLK_HZ / 1000 * LONG_PRESS_MS;
    localparam int GATE_CYC      = CLK_HZ / 1000 * GATE_MS;
    localparam int AUTO_CYC      = CLK_HZ / 1000 * AUTO_MS;
    localparam int PIN_LINE      = 0;
    localparam int PIN_RUN       = 1;
    localparam int PIN_SINGLE    = 2;
    localparam int PIN_FORCE     = 3;
    localparam int PIN_AUTOSET   = 4;
    localparam int PIN_TRIG      = 5;
    localparam int PINS          = 6;
    localparam logic [7:0] LVL_MID  = 8'h80;
    localparam logic [7:0] LVL_FULL = 8'hff;
    localparam logic [7:0] LVL_ZERO = 8'h00;

    typedef enum logic [1:0] {TAC_EDGE, TAC_VIDEO, TAC_PULSE} tac_type_e;
    typedef enum logic [1:0] {SRC_CH1, SRC_CH2, SRC_EXT, SRC_LINE} tac_src_e;
    typedef enum logic [1:0] {ACQ_SAMPLE, ACQ_PEAK, ACQ_AVG} tac_acq_e;
    typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_WAIT, ST_POST, ST_READ} tac_state_e;

    typedef struct packed {
        tac_type_e   trig_type;
        tac_src_e    src;
        logic        slope_fall;
        logic        mode_normal;
        logic        coupling_ac;
        logic [7:0]  level;
        tac_acq_e    acq;
        logic [15:0] pretrig;
        logic [15:0] tb_div;
        logic [15:0] pw_min;
    } tac_cfg_s;

    typedef struct packed {
        logic [7:0] ch2_lo;
        logic [7:0] ch2_hi;
        logic [7:0] ch1_lo;
        logic [7:0] ch1_hi;
    } tac_point_s;

    localparam tac_cfg_s CFG_RST = '{TAC_EDGE, SRC_CH1, 1'b0, 1'b0, 1'b0, 8'h80, ACQ_SAMPLE,
                                     16'h0200, 16'h0000, 16'h0010};
endpackage : tac_pkg

// ### sim/tac_properties.sv
// Checker on the top-level ports of trigger and acquisition control
module tac_properties (
    input wire logic              clk_in,
    input wire logic              rst_in,
    input wire logic              cfg_we_in,
    input wire logic              recall_in,
    input wire tac_pkg::tac_cfg_s setup_out,
    input wire logic              nv_commit_out,
    input wire logic              running_out,
    input wire logic              armed_out,
    input wire logic              triggered_out,
    input wire logic              disp_valid_out,
    input wire logic              disp_last_out,
    input wire logic              autoset_out,
    input wire logic              autorange_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // Reset clause needs its own disable, the default would mask it
    rst_values_a: assert property (@(posedge clk_in) disable iff (1'b0)
        rst_in |=> setup_out == tac_pkg::CFG_RST && !running_out && !nv_commit_out)
        else $error("reset values wrong");
    armed_run_a: assert property (armed_out |-> running_out)
        else $error("armed while stopped");
    trig_disarm_a: assert property (triggered_out |-> running_out && !armed_out ##1 !triggered_out)
        else $error("trigger pulse wrong");
    disp_burst_a: assert property ($rose(disp_valid_out) |-> disp_valid_out [*8])
        else $error("display burst broken");
    disp_last_a: assert property (disp_last_out |-> disp_valid_out ##1 !disp_valid_out)
        else $error("last point misplaced");
    disp_idle_a: assert property (disp_valid_out |-> !armed_out)
        else $error("readout while armed");
    commit_once_a: assert property (nv_commit_out |=> !nv_commit_out)
        else $error("commit repeated");
    commit_idle_a: assert property ((cfg_we_in || recall_in) |=> !nv_commit_out [*8])
        else $error("commit too soon");
    autoset_fixed_a: assert property (autoset_out |-> $stable(autorange_out))
        else $error("short press moved autorange");
endmodule : tac_properties

bind tac_top tac_properties u_props (.clk_in(clk_in), .rst_in(rst_in), .cfg_we_in(cfg_we_in),
    .recall_in(recall_in), .setup_out(setup_out), .nv_commit_out(nv_commit_out),
    .running_out(running_out), .armed_out(armed_out), .triggered_out(triggered_out),
    .disp_valid_out(disp_valid_out), .disp_last_out(disp_last_out), .autoset_out(autoset_out),
    .autorange_out(autorange_out));

// ### sim/tac_source.sv
// Far-side model: channel samples and mains level
module tac_source (
    input  wire logic       clk_in,
    output logic      [7:0] ch1_out = 8'h20,
    output logic      [7:0] ch2_out = 8'h00,
    output logic      [7:0] ext_out = 8'h40,
    output logic            line_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phase = 4'h0;
    // Half period 5 so any 8-clock interval holds both levels
    always @(posedge clk_in)
    begin
        phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
        ch1_out <= (phase < 4'h5) ? 8'he0 : 8'h20;
        ch2_out <= ch2_out + 8'h03;
        ext_out <= ~ext_out;
        line_out <= (phase == 4'h0) ? ~line_out : line_out;
    end
endmodule : tac_source

// ### sim/testbench.sv
// Self-checking bench for trigger and acquisition control
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk_in = 1'b0;
    logic                rst_in = 1'b1;
    logic          [4:0] btn = 5'h00;
    logic                cfg_we_in = 1'b0;
    logic                save_in = 1'b0;
    logic                recall_in = 1'b0;
    logic          [3:0] slot_in = 4'h0;
    tac_pkg::tac_cfg_s   cfg_in = tac_pkg::CFG_RST;
    tac_pkg::tac_cfg_s   setup_out;
    tac_pkg::tac_point_s disp_data_out;
    logic          [7:0] ch1, ch2, ext;
    logic         [31:0] trig_freq_out;
    logic                line, nv_commit_out, running_out, armed_out, triggered_out;
    logic                disp_valid_out, disp_last_out, trig_view_out, autoset_out, autorange_out;
    int                  error_cnt = 0;
    int                  check_count = 0;

    initial
    begin
        forever #2 clk_in = ~clk_in;
    end

    tac_source u_tac_source (.clk_in(clk_in), .ch1_out(ch1), .ch2_out(ch2), .ext_out(ext), .line_out(line));
    tac_top #(.REC_AW(4), .SAVE_CYC(200), .LONG_CYC(20), .GATE_CYC(100), .AUTO_CYC(50)) u_tac_top (
        .clk_in(clk_in), .rst_in(rst_in), .ch1_in(ch1), .ch2_in(ch2), .ext_in(ext), .line_in(line),
        .run_btn_in(btn[0]), .single_btn_in(btn[1]), .force_btn_in(btn[2]), .autoset_btn_in(btn[3]),
        .trig_btn_in(btn[4]), .cfg_we_in(cfg_we_in), .cfg_in(cfg_in), .save_in(save_in),
        .recall_in(recall_in), .slot_in(slot_in), .setup_out(setup_out), .nv_commit_out(nv_commit_out),
        .running_out(running_out), .armed_out(armed_out), .triggered_out(triggered_out),
        .disp_valid_out(disp_valid_out), .disp_data_out(disp_data_out), .disp_last_out(disp_last_out),
        .trig_freq_out(trig_freq_out), .trig_view_out(trig_view_out), .autoset_out(autoset_out),
        .autorange_out(autorange_out));

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [79:0] exp, input logic [79:0] act);
        check_count++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, act);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step

    task automatic bound(input int n, input int lim);
        if (n >= lim)
        begin
            error_cnt++;
            summarize();
        end
    endtask : bound

    task automatic write_cfg(input tac_pkg::tac_cfg_s c);
        @(posedge clk_in);
        cfg_in <= c;
        cfg_we_in <= 1'b1;
        @(posedge clk_in);
        cfg_we_in <= 1'b0;
    endtask : write_cfg

    task automatic slot_op(input logic is_save, input logic [3:0] s);
        @(posedge clk_in);
        slot_in <= s;
        save_in <= is_save;
        recall_in <= ~is_save;
        @(posedge clk_in);
        save_in <= 1'b0;
        recall_in <= 1'b0;
    endtask : slot_op

    task automatic press(input int idx, input int hold);
        @(posedge clk_in);
        btn[idx] <= 1'b1;
        repeat (hold) @(posedge clk_in);
        btn[idx] <= 1'b0;
    endtask : press

    // Save, recall, ignored slot, idle commit and restore across reset
    task automatic t_setup();
        tac_pkg::tac_cfg_s a;
        int commits;
        a = tac_pkg::CFG_RST;
        a.level = 8'h40;
        a.src = tac_pkg::SRC_CH2;
        write_cfg(a);
        step(1);
        chk(a, setup_out);
        slot_op(1'b1, 4'h3);
        write_cfg(tac_pkg::CFG_RST);
        slot_op(1'b0, 4'h3);
        slot_op(1'b0, 4'hc);
        step(1);
        chk(a, setup_out);
        commits = 0;
        repeat (260)
        begin
            step(1);
            commits += nv_commit_out;
        end
        chk(1, commits);
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        step(1);
        chk(a, setup_out);
        step(6);
    endtask : t_setup

    // One single-sequence record; peak mode expects both levels in every point
    // Sample run sets an unreachable level so only the auto trigger can fire
    task automatic t_single(input tac_pkg::tac_acq_e acq, input logic [15:0] div);
        tac_pkg::tac_cfg_s c;
        int n, pts, good, armed, trigs;
        c = tac_pkg::CFG_RST;
        c.acq = acq;
        c.pretrig = 16'h0004;
        c.tb_div = div;
        c.level = (acq == tac_pkg::ACQ_SAMPLE) ? tac_pkg::LVL_FULL : tac_pkg::LVL_MID;
        write_cfg(c);
        press(1, 8);
        for (n = 0; n < 40 && running_out !== 1'b1; n++) step(1);
        bound(n, 40);
        chk(1, running_out);
        pts = 0; good = 0; armed = 0; trigs = 0;
        for (n = 0; n < 3000 && disp_last_out !== 1'b1; n++)
        begin
            step(1);
            armed += armed_out;
            trigs += triggered_out;
            pts += disp_valid_out;
            good += (disp_valid_out === 1'b1) && (acq == tac_pkg::ACQ_PEAK ? disp_data_out.ch1_hi === 8'he0
                && disp_data_out.ch1_lo === 8'h20 : disp_data_out.ch1_hi inside {8'h20, 8'he0});
        end
        bound(n, 3000);
        chk(1, armed > 0);
        chk(1, trigs);
        chk(16, pts);
        chk(16, good);
        step(6);
        chk(0, running_out);
    endtask : t_single

    // Long press toggles autorange, short press gives one autoset
    task automatic t_buttons();
        logic prev;
        int pulses;
        prev = autorange_out;
        press(3, 40);
        step(10);
        chk(!prev, autorange_out);
        press(3, 8);
        pulses = 0;
        repeat (20)
        begin
            step(1);
            pulses += autoset_out;
        end
        chk(1, pulses);
        chk(!prev, autorange_out);
        @(posedge clk_in);
        btn[4] <= 1'b1;
        step(40);
        chk(1, trig_view_out);
        @(posedge clk_in);
        btn[4] <= 1'b0;
        step(10);
        chk(0, trig_view_out);
    endtask : t_buttons

    initial
    begin
        step(5);
        chk(tac_pkg::CFG_RST, setup_out);
        @(posedge clk_in);
        rst_in <= 1'b0;
        t_setup();
        t_single(tac_pkg::ACQ_SAMPLE, 16'h0000);
        t_single(tac_pkg::ACQ_PEAK, 16'h0007);
        step(200);
        // Ten rising crossings per gate, one either way for phase
        chk(1, trig_freq_out inside {[32'h9 : 32'hb]});
        t_buttons();
        summarize();
    end
endmodule : testbench
